// ### rtl/rcu_consts.vh
`ifndef RCU_CONSTS_VH
`define RCU_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RCU_OFS_STATUS 12'h100
`define RCU_OFS_FAST_BUS 12'h104
`define RCU_OFS_PERIPH0 12'h108
`define RCU_OFS_PERIPH1 12'h10C
`define RCU_OFS_IRQ_STATUS 12'h110
`define RCU_OFS_IRQ_MASK 12'h114

// ****************************************************************
// Reset values and implemented bit masks
// ****************************************************************
`define RCU_STATUS_RESET 4'h8
`define RCU_STATUS_MASK 32'h0000000F
`define RCU_FAST_BUS_MASK 32'h00000300
`define RCU_PERIPH0_MASK 32'h0000C511
`define RCU_PERIPH1_MASK 32'h31010110
`define RCU_IRQ_MASK_RESET 4'h0

// ****************************************************************
// Status field positions
// ****************************************************************
`define RCU_BIT_COLD 3
`define RCU_BIT_WDOG 2
`define RCU_BIT_PIN 1
`define RCU_BIT_SWREQ 0

// ****************************************************************
// Unit reset bit positions
// ****************************************************************
`define RCU_BIT_PORT_B 9
`define RCU_BIT_PORT_A 8
`define RCU_BIT_EXTI 15
`define RCU_BIT_AFIO 14
`define RCU_BIT_UART 10
`define RCU_BIT_USART 8
`define RCU_BIT_SPI 4
`define RCU_BIT_I2C 0
`define RCU_BIT_TMR1 29
`define RCU_BIT_TMR0 28
`define RCU_BIT_ADC 24
`define RCU_BIT_BTMR 16
`define RCU_BIT_GTMR 8
`define RCU_BIT_WDT 4

// ****************************************************************
// Timing
// ****************************************************************
`define RCU_CLK_PERIOD_NS 50
`define RCU_FILTER_TIME_NS 200
`define RCU_UNIT_HOLD_CYCLES 8

`endif

// ### rtl/rcu_reset_control_unit.v
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// - Cold, system and per-unit reset kinds
// - Cold reset reaches every block
// - System reset spares the debug controller
// - Cold reset inputs pass glitch filters
// - Core-supply reset holds until supply ready
// - Enabled brown-out raises flag, resets cold
// - System reset from four sources
// - Bus units reset on cold or system
// - Unit bits self-clear; zero writes ignored
// - Cold flag bit 3, write-1 clear
// - Watchdog flag bit 2, cleared also cold
// - Pin flag bit 1, cleared also cold
// - Request flag bit 0, cleared also cold
// - Fast bus bits 9 and 8 ports
// - Periph0 bits 15 interrupt, 14 pins
// - Periph0 bits 10, 8, 4, 0
// - Periph1 bits 29, 28, 24
// - Periph1 bits 16, 8, 4
`include "rcu_consts.vh"

module rcu_reset_control_unit #(
  parameter ADDR_W = 12,
  parameter FILTER_NS = `RCU_FILTER_TIME_NS,
  parameter HOLD_CYCLES = `RCU_UNIT_HOLD_CYCLES
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output wire irq,
  input wire ext_cold_reset_n,
  input wire gen_cold_reset_n,
  input wire core_supply_ready,
  input wire brownout_enable,
  input wire brownout_event,
  input wire watchdog_reset_n,
  input wire external_reset_pin_n,
  input wire software_system_reset_request,
  output reg core_supply_ready_reset_n,
  output reg brownout_flag_signal,
  output reg cold_reset_n,
  output reg system_reset_n,
  output reg debug_reset_n,
  output reg port_a_reset_n,
  output reg port_b_reset_n,
  output reg ext_interrupt_reset_n,
  output reg alt_function_reset_n,
  output reg uart_reset_n,
  output reg usart_reset_n,
  output reg spi_reset_n,
  output reg i2c_reset_n,
  output reg single_timer1_reset_n,
  output reg single_timer0_reset_n,
  output reg converter_reset_n,
  output reg basic_timer_reset_n,
  output reg general_timer_reset_n,
  output reg watchdog_unit_reset_n
);

  // ****************************************************************
  // Derived counts
  // ****************************************************************
  localparam FILTER_CYCLES = (FILTER_NS + `RCU_CLK_PERIOD_NS - 1) / `RCU_CLK_PERIOD_NS;
  localparam FILT_N = (FILTER_CYCLES < 1) ? 1 : FILTER_CYCLES;
  localparam FCW = 8;
  localparam HCW = 8;
  localparam NSRC = 3;

  // ****************************************************************
  // Glitch filters: ext cold, gen cold, reset pin
  // ****************************************************************
  wire [NSRC-1:0] raw_low;
  wire [NSRC-1:0] filt_low;
  assign raw_low = {~external_reset_pin_n, ~gen_cold_reset_n, ~ext_cold_reset_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1)
    begin : g_filt
      reg [FCW-1:0] cnt;
      reg flt;
      assign filt_low[gi] = flt;
      always @(posedge core_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          cnt <= {FCW{1'b0}};
          flt <= 1'b0;
        end
        else if (raw_low[gi] == flt)
        begin
          cnt <= {FCW{1'b0}};
        end
        else if (cnt == FILT_N[FCW-1:0] - 8'h01)
        begin
          cnt <= {FCW{1'b0}};
          flt <= raw_low[gi];
        end
        else
        begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  wire power_down_reset;
  wire cold_src;
  wire wdog_src;
  wire pin_src;
  wire swreq_src;
  wire sys_src;
  assign power_down_reset = brownout_enable & brownout_event;
  assign cold_src = filt_low[0] | filt_low[1] | ~core_supply_ready | power_down_reset;
  assign wdog_src = ~watchdog_reset_n;
  assign pin_src = filt_low[2];
  assign swreq_src = software_system_reset_request;
  assign sys_src = cold_src | wdog_src | pin_src | swreq_src;

  reg [3:0] src_q;
  wire [3:0] src_now;
  wire [3:0] src_rise;
  assign src_now = {cold_src, wdog_src, pin_src, swreq_src};
  assign src_rise = src_now & ~src_q;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  function hit;
    input [ADDR_W-1:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire wr_status;
  wire wr_fast;
  wire wr_p0;
  wire wr_p1;
  wire wr_mask;
  wire rd_irq;
  assign wr_status = reg_wr & hit(reg_addr, `RCU_OFS_STATUS);
  assign wr_fast = reg_wr & hit(reg_addr, `RCU_OFS_FAST_BUS);
  assign wr_p0 = reg_wr & hit(reg_addr, `RCU_OFS_PERIPH0);
  assign wr_p1 = reg_wr & hit(reg_addr, `RCU_OFS_PERIPH1);
  assign wr_mask = reg_wr & hit(reg_addr, `RCU_OFS_IRQ_MASK);
  assign rd_irq = reg_rd & hit(reg_addr, `RCU_OFS_IRQ_STATUS);

  // ****************************************************************
  // Reset status flags
  // ****************************************************************
  reg [3:0] status;
  reg [3:0] next_status;
  always @*
  begin
    next_status = status;
    if (wr_status)
    begin
      next_status = status & ~reg_wdata[3:0];
    end
    next_status[`RCU_BIT_WDOG] = next_status[`RCU_BIT_WDOG] | wdog_src;
    next_status[`RCU_BIT_PIN] = next_status[`RCU_BIT_PIN] | pin_src;
    next_status[`RCU_BIT_SWREQ] = next_status[`RCU_BIT_SWREQ] | swreq_src;
    if (cold_src)
    begin
      next_status[`RCU_BIT_WDOG] = 1'b0;
      next_status[`RCU_BIT_PIN] = 1'b0;
      next_status[`RCU_BIT_SWREQ] = 1'b0;
      next_status[`RCU_BIT_COLD] = 1'b1;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  wire [3:0] next_irq_status;
  assign next_irq_status = (rd_irq ? 4'h0 : irq_status) | src_rise;
  assign irq = |(irq_status & irq_mask);

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status <= `RCU_STATUS_RESET;
      src_q <= 4'h0;
      irq_status <= 4'h0;
      irq_mask <= `RCU_IRQ_MASK_RESET;
    end
    else
    begin
      status <= next_status;
      src_q <= src_now;
      irq_status <= next_irq_status;
      if (wr_mask)
      begin
        irq_mask <= reg_wdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Self-clearing unit reset bits
  // ****************************************************************
  reg [31:0] fast_bits;
  reg [31:0] p0_bits;
  reg [31:0] p1_bits;
  reg [HCW-1:0] fast_cnt;
  reg [HCW-1:0] p0_cnt;
  reg [HCW-1:0] p1_cnt;
  wire [31:0] fast_set;
  wire [31:0] p0_set;
  wire [31:0] p1_set;
  assign fast_set = wr_fast ? (reg_wdata & `RCU_FAST_BUS_MASK) : 32'h00000000;
  assign p0_set = wr_p0 ? (reg_wdata & `RCU_PERIPH0_MASK) : 32'h00000000;
  assign p1_set = wr_p1 ? (reg_wdata & `RCU_PERIPH1_MASK) : 32'h00000000;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fast_bits <= 32'h00000000;
      p0_bits <= 32'h00000000;
      p1_bits <= 32'h00000000;
      fast_cnt <= {HCW{1'b0}};
      p0_cnt <= {HCW{1'b0}};
      p1_cnt <= {HCW{1'b0}};
    end
    else
    begin
      if (fast_set != 32'h00000000)
      begin
        fast_bits <= fast_bits | fast_set;
        fast_cnt <= HOLD_CYCLES[HCW-1:0];
      end
      else if (fast_cnt > 8'h01)
      begin
        fast_cnt <= fast_cnt - 8'h01;
      end
      else
      begin
        fast_cnt <= {HCW{1'b0}};
        fast_bits <= 32'h00000000;
      end
      if (p0_set != 32'h00000000)
      begin
        p0_bits <= p0_bits | p0_set;
        p0_cnt <= HOLD_CYCLES[HCW-1:0];
      end
      else if (p0_cnt > 8'h01)
      begin
        p0_cnt <= p0_cnt - 8'h01;
      end
      else
      begin
        p0_cnt <= {HCW{1'b0}};
        p0_bits <= 32'h00000000;
      end
      if (p1_set != 32'h00000000)
      begin
        p1_bits <= p1_bits | p1_set;
        p1_cnt <= HOLD_CYCLES[HCW-1:0];
      end
      else if (p1_cnt > 8'h01)
      begin
        p1_cnt <= p1_cnt - 8'h01;
      end
      else
      begin
        p1_cnt <= {HCW{1'b0}};
        p1_bits <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Reset outputs
  // ****************************************************************
  wire hw_unit;
  assign hw_unit = cold_src | sys_src;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_supply_ready_reset_n <= 1'b0;
      brownout_flag_signal <= 1'b0;
      cold_reset_n <= 1'b0;
      system_reset_n <= 1'b0;
      debug_reset_n <= 1'b0;
      port_a_reset_n <= 1'b0;
      port_b_reset_n <= 1'b0;
      ext_interrupt_reset_n <= 1'b0;
      alt_function_reset_n <= 1'b0;
      uart_reset_n <= 1'b0;
      usart_reset_n <= 1'b0;
      spi_reset_n <= 1'b0;
      i2c_reset_n <= 1'b0;
      single_timer1_reset_n <= 1'b0;
      single_timer0_reset_n <= 1'b0;
      converter_reset_n <= 1'b0;
      basic_timer_reset_n <= 1'b0;
      general_timer_reset_n <= 1'b0;
      watchdog_unit_reset_n <= 1'b0;
    end
    else
    begin
      core_supply_ready_reset_n <= core_supply_ready;
      brownout_flag_signal <= power_down_reset;
      cold_reset_n <= ~cold_src;
      system_reset_n <= ~sys_src;
      debug_reset_n <= ~cold_src;
      port_a_reset_n <= ~(hw_unit | fast_bits[`RCU_BIT_PORT_A]);
      port_b_reset_n <= ~(hw_unit | fast_bits[`RCU_BIT_PORT_B]);
      ext_interrupt_reset_n <= ~(hw_unit | p0_bits[`RCU_BIT_EXTI]);
      alt_function_reset_n <= ~(hw_unit | p0_bits[`RCU_BIT_AFIO]);
      uart_reset_n <= ~(hw_unit | p0_bits[`RCU_BIT_UART]);
      usart_reset_n <= ~(hw_unit | p0_bits[`RCU_BIT_USART]);
      spi_reset_n <= ~(hw_unit | p0_bits[`RCU_BIT_SPI]);
      i2c_reset_n <= ~(hw_unit | p0_bits[`RCU_BIT_I2C]);
      single_timer1_reset_n <= ~(hw_unit | p1_bits[`RCU_BIT_TMR1]);
      single_timer0_reset_n <= ~(hw_unit | p1_bits[`RCU_BIT_TMR0]);
      converter_reset_n <= ~(hw_unit | p1_bits[`RCU_BIT_ADC]);
      basic_timer_reset_n <= ~(hw_unit | p1_bits[`RCU_BIT_BTMR]);
      general_timer_reset_n <= ~(hw_unit | p1_bits[`RCU_BIT_GTMR]);
      watchdog_unit_reset_n <= ~(hw_unit | p1_bits[`RCU_BIT_WDT]);
    end
  end

  // ****************************************************************
  // Read data, one cycle after the strobe
  // ****************************************************************
  reg [31:0] next_rdata;
  always @*
  begin
    next_rdata = 32'h00000000;
    if (reg_rd)
    begin
      if (hit(reg_addr, `RCU_OFS_STATUS))
      begin
        next_rdata = {28'h0000000, status};
      end
      else if (hit(reg_addr, `RCU_OFS_FAST_BUS))
      begin
        next_rdata = fast_bits & `RCU_FAST_BUS_MASK;
      end
      else if (hit(reg_addr, `RCU_OFS_PERIPH0))
      begin
        next_rdata = p0_bits & `RCU_PERIPH0_MASK;
      end
      else if (hit(reg_addr, `RCU_OFS_PERIPH1))
      begin
        next_rdata = p1_bits & `RCU_PERIPH1_MASK;
      end
      else if (hit(reg_addr, `RCU_OFS_IRQ_STATUS))
      begin
        next_rdata = {28'h0000000, irq_status};
      end
      else if (hit(reg_addr, `RCU_OFS_IRQ_MASK))
      begin
        next_rdata = {28'h0000000, irq_mask};
      end
      else
      begin
        next_rdata = 32'h00000000;
      end
    end
  end

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // rcu_reset_control_unit

// ### verif/rcu_periph_model.sv
`timescale 1ns/1ps
// ****
// Receivers of the unit resets
// ****
module rcu_periph_model (
  input wire core_clk,
  input wire [13:0] unit_rst_n,
  input wire clr,
  output reg [13:0] hit,
  output reg [7:0] low_cyc
);
  // Records which units saw a reset and for how many cycles
  always @(posedge core_clk)
  begin
    if (clr)
    begin
      hit <= 14'h0;
      low_cyc <= 8'h0;
    end
    else
    begin
      hit <= hit | ~unit_rst_n;
      if (unit_rst_n != 14'h3FFF)
        low_cyc <= low_cyc + 8'h1;
    end
  end
endmodule // rcu_periph_model

// ### verif/rcu_props.sv
`timescale 1ns/1ps
// ****
// Reset unit checker
// ****
module rcu_props #(
  parameter ADDR_W = 12
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire core_supply_ready,
  input wire brownout_enable,
  input wire brownout_event,
  input wire watchdog_reset_n,
  input wire external_reset_pin_n,
  input wire software_system_reset_request,
  input wire core_supply_ready_reset_n,
  input wire brownout_flag_signal,
  input wire cold_reset_n,
  input wire system_reset_n,
  input wire debug_reset_n,
  input wire port_a_reset_n,
  input wire uart_reset_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero");
  AST_STS_RSV: assert property (reg_rd && reg_addr == 12'h100 |=> reg_rdata[31:4] == 28'h0)
    else $error("status reserved bits set");
  AST_WDOG: assert property (!watchdog_reset_n |=> !system_reset_n)
    else $error("watchdog missed");
  AST_SWREQ: assert property (software_system_reset_request |=> !system_reset_n)
    else $error("request missed");
  AST_DBG: assert property (debug_reset_n == cold_reset_n)
    else $error("debug reset wrong");
  AST_COLD: assert property (!cold_reset_n |-> !system_reset_n && !port_a_reset_n)
    else $error("cold reset not global");
  AST_UNITS: assert property (!system_reset_n |-> !port_a_reset_n && !uart_reset_n)
    else $error("unit not reset");
  AST_SUPPLY: assert property (!core_supply_ready |=> !core_supply_ready_reset_n && !cold_reset_n)
    else $error("supply reset missed");
  AST_SUP_UP: assert property ($rose(core_supply_ready) |=> core_supply_ready_reset_n)
    else $error("supply reset stuck");
  AST_BROWN: assert property (brownout_enable && brownout_event |=> brownout_flag_signal ##[0:1] !cold_reset_n)
    else $error("brown-out missed");
  AST_NO_BROWN: assert property (!brownout_enable |=> !brownout_flag_signal)
    else $error("brown-out flag unexpected");
  AST_HOLD: assert property (reg_wr && reg_addr == 12'h104 && reg_wdata[8] |=> ##1 !port_a_reset_n [*8])
    else $error("unit pulse too short");
  AST_FILTER: assert property ((external_reset_pin_n && watchdog_reset_n && !software_system_reset_request && cold_reset_n) [*6] |-> system_reset_n)
    else $error("system reset without cause");
  cover property (!watchdog_reset_n ##1 !system_reset_n);
  cover property (brownout_flag_signal ##1 !cold_reset_n);
  cover property (reg_wr && reg_addr == 12'h104 && reg_wdata[8]);
endmodule // rcu_props

bind rcu_reset_control_unit rcu_props #(.ADDR_W(ADDR_W)) u_props (.core_clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_supply_ready, .brownout_enable,
  .brownout_event, .watchdog_reset_n, .external_reset_pin_n, .software_system_reset_request,
  .core_supply_ready_reset_n, .brownout_flag_signal, .cold_reset_n, .system_reset_n,
  .debug_reset_n, .port_a_reset_n, .uart_reset_n);

// ### verif/rcu_reset_control_unit_tb.sv
`timescale 1ns/1ps
// ****
// Reset unit bench
// ****
module rcu_reset_control_unit_tb;
  logic core_clk, sys_rst, reg_wr, reg_rd, clr;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic ext_cold_reset_n, gen_cold_reset_n, core_supply_ready, brownout_enable, brownout_event;
  logic watchdog_reset_n, external_reset_pin_n, software_system_reset_request;
  wire [31:0] reg_rdata;
  wire irq, core_supply_ready_reset_n, brownout_flag_signal, cold_reset_n, system_reset_n;
  wire debug_reset_n, port_a_reset_n, port_b_reset_n, ext_interrupt_reset_n, uart_reset_n;
  wire alt_function_reset_n, usart_reset_n, spi_reset_n, i2c_reset_n, converter_reset_n;
  wire single_timer1_reset_n, single_timer0_reset_n, basic_timer_reset_n;
  wire general_timer_reset_n, watchdog_unit_reset_n;
  wire [13:0] uv, hit;
  wire [7:0] low_cyc;
  integer err_total, compares, cyc;
  int ub [0:13] = '{8, 9, 15, 14, 10, 8, 4, 0, 29, 28, 24, 16, 8, 4};
  assign uv = {port_a_reset_n, port_b_reset_n, ext_interrupt_reset_n, alt_function_reset_n,
    uart_reset_n, usart_reset_n, spi_reset_n, i2c_reset_n, single_timer1_reset_n,
    single_timer0_reset_n, converter_reset_n, basic_timer_reset_n, general_timer_reset_n,
    watchdog_unit_reset_n};
  rcu_reset_control_unit uut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .ext_cold_reset_n, .gen_cold_reset_n, .core_supply_ready,
    .brownout_enable, .brownout_event, .watchdog_reset_n, .external_reset_pin_n,
    .software_system_reset_request, .core_supply_ready_reset_n, .brownout_flag_signal,
    .cold_reset_n, .system_reset_n, .debug_reset_n, .port_a_reset_n, .port_b_reset_n,
    .ext_interrupt_reset_n, .alt_function_reset_n, .uart_reset_n, .usart_reset_n,
    .spi_reset_n, .i2c_reset_n, .single_timer1_reset_n, .single_timer0_reset_n,
    .converter_reset_n, .basic_timer_reset_n, .general_timer_reset_n, .watchdog_unit_reset_n);
  rcu_periph_model far_end (.core_clk, .unit_rst_n(uv), .clr, .hit, .low_cyc);
  // ****
  // Shared tasks
  // ****
  task chk(input [31:0] g, input [31:0] e);
    compares = compares + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [11:0] a, input [31:0] e, input bit k);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    if (k)
      chk(reg_rdata, e);
  endtask
  task give_verdict;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task t_regs;
    rd(12'h110, 32'h0, 1'b1);
    rd(12'h100, 32'h8, 1'b1);
    rd(12'h104, 32'h0, 1'b1);
    rd(12'h108, 32'h0, 1'b1);
    rd(12'h10C, 32'h0, 1'b1);
    wr(12'h1F0, 32'hFFFFFFFF);
    rd(12'h1F0, 32'h0, 1'b1);
    wr(12'h100, 32'h7);
    rd(12'h100, 32'h8, 1'b1);
    wr(12'h100, 32'h8);
    rd(12'h100, 32'h0, 1'b1);
    $display("t_regs done");
  endtask
  task t_wdog;
    wr(12'h114, 32'h4);
    rd(12'h114, 32'h4, 1'b1);
    @(posedge core_clk);
    watchdog_reset_n <= 1'b0;
    tick(2);
    chk(32'({system_reset_n, debug_reset_n, port_a_reset_n}), 32'h2);
    wr(12'h100, 32'h4);
    rd(12'h100, 32'h4, 1'b1);
    @(posedge core_clk);
    watchdog_reset_n <= 1'b1;
    tick(3);
    chk(32'({irq, system_reset_n}), 32'h3);
    rd(12'h110, 32'h4, 1'b1);
    chk(32'(irq), 32'h0);
    rd(12'h100, 32'h4, 1'b1);
    wr(12'h100, 32'h4);
    rd(12'h100, 32'h0, 1'b1);
    wr(12'h114, 32'h0);
    @(posedge core_clk);
    software_system_reset_request <= 1'b1;
    @(posedge core_clk);
    software_system_reset_request <= 1'b0;
    tick(3);
    chk(32'(irq), 32'h0);
    rd(12'h110, 32'h1, 1'b1);
    rd(12'h100, 32'h1, 1'b1);
    $display("t_wdog done");
  endtask
  task t_pin;
    @(posedge core_clk);
    external_reset_pin_n <= 1'b0;
    tick(2);
    chk(32'(system_reset_n), 32'h1);
    @(posedge core_clk);
    external_reset_pin_n <= 1'b1;
    gen_cold_reset_n <= 1'b0;
    tick(2);
    chk(32'({system_reset_n, cold_reset_n}), 32'h3);
    @(posedge core_clk);
    gen_cold_reset_n <= 1'b1;
    external_reset_pin_n <= 1'b0;
    tick(7);
    chk(32'(system_reset_n), 32'h0);
    @(posedge core_clk);
    external_reset_pin_n <= 1'b1;
    tick(7);
    chk(32'(system_reset_n), 32'h1);
    rd(12'h100, 32'h3, 1'b1);
    @(posedge core_clk);
    ext_cold_reset_n <= 1'b0;
    tick(7);
    chk(32'({cold_reset_n, debug_reset_n, system_reset_n, uart_reset_n}), 32'h0);
    @(posedge core_clk);
    ext_cold_reset_n <= 1'b1;
    tick(8);
    rd(12'h100, 32'h8, 1'b1);
    wr(12'h100, 32'h8);
    $display("t_pin done");
  endtask
  task t_power;
    @(posedge core_clk);
    core_supply_ready <= 1'b0;
    tick(2);
    chk(32'({core_supply_ready_reset_n, cold_reset_n}), 32'h0);
    @(posedge core_clk);
    core_supply_ready <= 1'b1;
    brownout_event <= 1'b1;
    tick(6);
    chk(32'({core_supply_ready_reset_n, brownout_flag_signal, cold_reset_n}), 32'h5);
    @(posedge core_clk);
    brownout_enable <= 1'b1;
    tick(3);
    chk(32'({brownout_flag_signal, cold_reset_n}), 32'h2);
    @(posedge core_clk);
    brownout_enable <= 1'b0;
    brownout_event <= 1'b0;
    tick(8);
    chk(32'({brownout_flag_signal, cold_reset_n}), 32'h1);
    wr(12'h100, 32'h8);
    $display("t_power done");
  endtask
  task t_units;
    integer i;
    logic [11:0] a;
    for (i = 0; i < 14; i = i + 1)
    begin
      a = (i < 2) ? 12'h104 : (i < 8) ? 12'h108 : 12'h10C;
      @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      wr(a, 32'h1 << ub[i]);
      rd(a, 32'h1 << ub[i], 1'b1);
      tick(10);
      chk(32'(hit), 32'h1 << (13 - i));
      chk(32'(low_cyc), 32'h8);
      rd(a, 32'h0, 1'b1);
    end
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    wr(12'h108, 32'h0);
    tick(3);
    chk(32'(hit), 32'h0);
    wr(12'h104, 32'hFFFFFFFF);
    wr(12'h108, 32'hFFFFFFFF);
    wr(12'h10C, 32'hFFFFFFFF);
    rd(12'h104, 32'h00000300, 1'b1);
    rd(12'h108, 32'h0000C511, 1'b1);
    rd(12'h10C, 32'h31010110, 1'b1);
    tick(12);
    $display("t_units done");
  endtask
  // ****
  // Clock, reset, sequence and timeout
  // ****
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    {reg_wr, reg_rd, clr, brownout_enable, brownout_event} = 5'h0;
    {ext_cold_reset_n, gen_cold_reset_n, core_supply_ready} = 3'h7;
    {watchdog_reset_n, external_reset_pin_n, software_system_reset_request} = 3'h6;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    err_total = 0;
    compares = 0;
    cyc = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(10);
    t_regs;
    t_wdog;
    t_pin;
    t_power;
    t_units;
    give_verdict;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
endmodule // rcu_reset_control_unit_tb
